// *** verilog/dtc_pkg.sv ***
package dtc_pkg;
  // Widths of the latency path
  localparam int unsigned LAT_W       = 6;
  localparam int unsigned CK_FIELD_W  = 5;
  // Register byte addresses
  localparam logic [7:0] ADR_MR0      = 8'h00;
  localparam logic [7:0] ADR_MR1      = 8'h04;
  localparam logic [7:0] ADR_MR2      = 8'h08;
  localparam logic [7:0] ADR_LAT      = 8'h0c;
  localparam logic [7:0] ADR_STAT     = 8'h10;
  // Mode and latency register field positions
  localparam int unsigned MR0_BL_LSB  = 0;
  localparam int unsigned MR0_DLL_PD  = 12;
  localparam int unsigned MR1_NOM_HI  = 9;
  localparam int unsigned MR1_NOM_MID = 6;
  localparam int unsigned MR1_NOM_LO  = 2;
  localparam int unsigned MR1_AL_LSB  = 3;
  localparam int unsigned MR2_WR_LSB  = 9;
  localparam int unsigned LAT_CL_LSB  = 0;
  localparam int unsigned LAT_CWL_LSB = 8;
  // Status register bit positions
  localparam int unsigned ST_TERM_ON  = 0;
  localparam int unsigned ST_STR_LSB  = 1;
  localparam int unsigned ST_WR_WIN   = 4;
  localparam int unsigned ST_SYNC     = 5;
  localparam int unsigned ST_DYN_EN   = 6;
  localparam int unsigned ST_CFG_BAD  = 7;
  localparam int unsigned ST_DLL_WR   = 8;
  localparam int unsigned ST_HOLD_ERR = 9;
  // Reset values
  localparam logic [15:0] MR_RST      = 16'h0000;
  localparam logic [4:0]  CL_RST      = 5'h06;
  localparam logic [4:0]  CWL_RST     = 5'h05;
  // Burst length field and additive latency codes
  localparam logic [1:0] BL_FIXED8    = 2'h0;
  localparam logic [1:0] BL_OTF       = 2'h1;
  localparam logic [1:0] BL_FIXED4    = 2'h2;
  localparam logic [1:0] AL_ZERO      = 2'h0;
  localparam logic [1:0] AL_CL_M1     = 2'h1;
  localparam logic [1:0] AL_CL_M2     = 2'h2;
  // Latency figures in clock cycles
  localparam logic [7:0] WL_OFFSET    = 8'h02;
  localparam logic [7:0] HOLD_CHOP    = 8'h04;
  localparam logic [7:0] HOLD_FULL    = 8'h06;
  localparam logic [7:0] LAT_MIN      = 8'h01;
  localparam logic [7:0] LAT_MAX      = 8'(2 ** LAT_W - 1) - HOLD_FULL;
  // Strength change skew in tenths of a clock, rounded up to cycles
  localparam int unsigned SKEW_NOM_TENTHS = 5;
  localparam int unsigned SKEW_TOL_TENTHS = 2;
  localparam int unsigned TENTHS_PER_CK   = 10;
  localparam logic [1:0]  SKEW_CYCLES     =
    2'((SKEW_NOM_TENTHS + SKEW_TOL_TENTHS + TENTHS_PER_CK - 1) / TENTHS_PER_CK);
  localparam logic [2:0]  HOLD_CNT_MAX    = 3'h7;
  // Termination strength as a divisor of the reference resistor
  typedef enum logic [2:0] {
    STR_OFF, STR_DIV4, STR_DIV2, STR_DIV6, STR_DIV12, STR_DIV8, STR_RESERVED
  } dtc_strength_t;
endpackage : dtc_pkg

// *** verilog/dtc_sched_if.sv ***
`timescale 1ns/1ps
interface dtc_sched_if #(parameter int unsigned LAT_W = 6);
  logic             ball;
  logic [LAT_W-1:0] ball_sel;
  logic             ball_late;
  logic             wr_evt;
  logic             chop;
  logic [LAT_W-1:0] start_sel;
  logic [LAT_W-1:0] end4_sel;
  logic [LAT_W-1:0] end6_sel;
  logic             switch_evt;
  logic             return_evt;
  modport ctl (output ball, ball_sel, wr_evt, chop, start_sel, end4_sel, end6_sel,
               input ball_late, switch_evt, return_evt);
  modport dly (input ball, ball_sel, output ball_late);
  modport win (input wr_evt, chop, start_sel, end4_sel, end6_sel, output switch_evt, return_evt);
endinterface : dtc_sched_if

// *** verilog/dtc_delay_line.sv ***
`timescale 1ns/1ps
module dtc_delay_line #(
  parameter int unsigned DEPTH = 63
) (
  // Clock and reset
  input wire logic clock_i,
  input wire logic rst_b_i,
  // Control ball and tap
  dtc_sched_if.dly sched
);
  logic [DEPTH-1:0] line_q;

  // Shift the sampled control ball one stage per clock
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      line_q <= '0;
    end else begin
      line_q <= {line_q[DEPTH-2:0], sched.ball};
    end
  end

  // Tap zero is the live sample; tap n is n clocks old
  always_comb begin
    if (sched.ball_sel == '0) begin
      sched.ball_late = sched.ball;
    end else begin
      sched.ball_late = line_q[sched.ball_sel - 1'b1];
    end
  end
endmodule : dtc_delay_line

// *** verilog/dtc_write_window.sv ***
`timescale 1ns/1ps
module dtc_write_window #(
  parameter int unsigned DEPTH = 63,
  parameter int unsigned LAT_W = 6
) (
  // Clock and reset
  input wire logic clock_i,
  input wire logic rst_b_i,
  // Write events and switch points
  dtc_sched_if.win sched
);
  logic [DEPTH-1:0] evt_q;
  logic [DEPTH-1:0] chop_q;

  // Pick a stage of a line, tap zero being the live input
  function automatic logic tap_at(input logic [DEPTH-1:0] line, input logic now,
                                  input logic [LAT_W-1:0] sel);
    if (sel == '0) begin
      tap_at = now;
    end else begin
      tap_at = line[sel - 1'b1];
    end
  endfunction : tap_at

  // Each write travels down the line with its burst chop flag
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      evt_q  <= '0;
      chop_q <= '0;
    end else begin
      evt_q  <= {evt_q[DEPTH-2:0], sched.wr_evt};
      chop_q <= {chop_q[DEPTH-2:0], sched.chop};
    end
  end

  // Switch and return points; the return tap depends on the burst
  assign sched.switch_evt = tap_at(evt_q, sched.wr_evt, sched.start_sel);
  assign sched.return_evt =
    (tap_at(evt_q, sched.wr_evt, sched.end4_sel) & tap_at(chop_q, sched.chop, sched.end4_sel)) |
    (tap_at(evt_q, sched.wr_evt, sched.end6_sel) & !tap_at(chop_q, sched.chop, sched.end6_sel));
endmodule : dtc_write_window

// *** verilog/dtc_termination_ctl.sv ***
`timescale 1ns/1ps
module dtc_termination_ctl
  import dtc_pkg::*;
#(
  parameter int unsigned     DEPTH   = 63,
  parameter logic [4:0]      CL_INIT  = dtc_pkg::CL_RST,
  parameter logic [4:0]      CWL_INIT = dtc_pkg::CWL_RST
) (
  // Clock and reset
  input  wire logic                  clock_i,
  input  wire logic                  rst_b_i,
  // Wishbone register slave
  input  wire logic                  wb_cyc_i,
  input  wire logic                  wb_stb_i,
  input  wire logic                  wb_we_i,
  input  wire logic [7:0]            wb_adr_i,
  input  wire logic [3:0]            wb_sel_i,
  input  wire logic [31:0]           wb_dat_i,
  output logic      [31:0]           wb_dat_o,
  output logic                       wb_ack_o,
  // Control ball and commands
  input  wire logic                  term_ctl_i,
  input  wire logic                  wr_cmd_i,
  input  wire logic                  otf_chop_i,
  // Device power and DLL state
  input  wire logic                  cke_i,
  input  wire logic                  self_refresh_i,
  input  wire logic                  power_down_i,
  input  wire logic                  bank_open_i,
  input  wire logic                  dll_locked_i,
  // Termination outputs
  output logic                       term_on_o,
  output dtc_pkg::dtc_strength_t     term_strength_o,
  output logic                       strength_undefined_o,
  output logic                       write_window_o,
  output logic                       sync_mode_o
);
  import dtc_pkg::*;

  // Software visible state
  logic [15:0]     mr0_q;
  logic [15:0]     mr1_q;
  logic [15:0]     mr2_q;
  logic [4:0]      cl_q;
  logic [4:0]      cwl_q;
  logic            hold_err_q;
  logic            ack_q;
  logic [31:0]     rdat_q;
  // Termination state
  logic            term_on_q;
  dtc_strength_t   strength_q;
  dtc_strength_t   strength_d;
  logic            undef_q;
  logic [1:0]      skew_cnt_q;
  logic            win_q;
  logic            sync_q;
  // Control ball hold tracking
  logic            ball_prev_q;
  logic [2:0]      hold_cnt_q;
  logic [2:0]      hold_need_q;
  // Decoded configuration
  dtc_strength_t   nom_str;
  dtc_strength_t   wr_str;
  logic            dyn_en;
  logic            term_en;
  logic            cfg_bad;
  logic            sync_ok;
  logic            chop;
  logic            ball;
  logic [4:0]      al_cyc;
  logic [7:0]      wl;
  logic [7:0]      lat;
  logic            bus_req;
  logic            bus_wr;
  logic            hold_viol;
  logic [31:0]     status;

  dtc_sched_if #(.LAT_W(LAT_W)) sched ();

  // Nominal strength from the three scattered bits
  function automatic dtc_strength_t decode_nominal(input logic [15:0] mr);
    logic [2:0] code;
    code = {mr[MR1_NOM_HI], mr[MR1_NOM_MID], mr[MR1_NOM_LO]};
    case (code)
      3'h0:    decode_nominal = STR_OFF;
      3'h1:    decode_nominal = STR_DIV4;
      3'h2:    decode_nominal = STR_DIV2;
      3'h3:    decode_nominal = STR_DIV6;
      3'h4:    decode_nominal = STR_DIV12;
      3'h5:    decode_nominal = STR_DIV8;
      default: decode_nominal = STR_RESERVED;
    endcase
  endfunction : decode_nominal

  // Write strength from the two-bit field
  function automatic dtc_strength_t decode_write(input logic [15:0] mr);
    case (mr[MR2_WR_LSB +: 2])
      2'h0:    decode_write = STR_OFF;
      2'h1:    decode_write = STR_DIV4;
      2'h2:    decode_write = STR_DIV2;
      default: decode_write = STR_RESERVED;
    endcase
  endfunction : decode_write

  // Byte-lane merge for the 16-bit registers
  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] wd,
                                          input logic [3:0] sel);
    merge16 = old;
    if (sel[0]) begin
      merge16[7:0] = wd[7:0];
    end
    if (sel[1]) begin
      merge16[15:8] = wd[15:8];
    end
  endfunction : merge16

  // Configuration decode
  assign nom_str = decode_nominal(mr1_q);
  assign wr_str  = decode_write(mr2_q);
  assign dyn_en  = mr2_q[MR2_WR_LSB] | mr2_q[MR2_WR_LSB + 1];
  assign term_en = (nom_str != STR_OFF) | dyn_en;
  // Reserved strengths or additive latency code flag a bad setup
  assign cfg_bad = (nom_str == STR_RESERVED) | (wr_str == STR_RESERVED) |
                   (mr1_q[MR1_AL_LSB +: 2] == 2'h3);

  // Power states in which timing follows the clock
  assign sync_ok = dll_locked_i & term_en & !self_refresh_i &
                   ((cke_i & !power_down_i) |
                    (power_down_i & bank_open_i) |
                    (power_down_i & !bank_open_i & mr0_q[MR0_DLL_PD]));

  // Burst chop: fixed by mode or chosen per command
  assign chop = (mr0_q[MR0_BL_LSB +: 2] == BL_FIXED4) |
                ((mr0_q[MR0_BL_LSB +: 2] == BL_OTF) & otf_chop_i);

  // Additive latency in clocks
  always_comb begin
    case (mr1_q[MR1_AL_LSB +: 2])
      AL_CL_M1: al_cyc = 5'(cl_q - 5'h01);
      AL_CL_M2: al_cyc = 5'(cl_q - 5'h02);
      default:  al_cyc = 5'h00;
    endcase
  end

  // Write latency and the shared on, off and switch latency
  always_comb begin
    wl = 8'(cwl_q) + 8'(al_cyc);
    if (wl < (WL_OFFSET + LAT_MIN)) begin
      lat = LAT_MIN;
    end else if ((wl - WL_OFFSET) > LAT_MAX) begin
      lat = LAT_MAX;
    end else begin
      lat = wl - WL_OFFSET;
    end
  end

  // Ball is masked in self refresh
  assign ball = term_ctl_i & !self_refresh_i;

  // Schedule taps; the ball tap includes the additive latency
  assign sched.ball      = ball;
  assign sched.ball_sel  = lat[LAT_W-1:0];
  assign sched.wr_evt    = wr_cmd_i;
  assign sched.chop      = chop;
  assign sched.start_sel = lat[LAT_W-1:0];
  assign sched.end4_sel  = 6'(lat + HOLD_CHOP);
  assign sched.end6_sel  = 6'(lat + HOLD_FULL);

  dtc_delay_line #(
    .DEPTH   (DEPTH)
  ) u_ball_delay (
    .clock_i (clock_i),
    .rst_b_i (rst_b_i),
    .sched   (sched.dly)
  );

  dtc_write_window #(
    .DEPTH   (DEPTH),
    .LAT_W   (LAT_W)
  ) u_write_window (
    .clock_i (clock_i),
    .rst_b_i (rst_b_i),
    .sched   (sched.win)
  );

  // Bus request decode
  assign bus_req = wb_cyc_i & wb_stb_i & !ack_q;
  assign bus_wr  = bus_req & wb_we_i;

  // Mode register copies
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      mr0_q <= MR_RST;
      mr1_q <= MR_RST;
      mr2_q <= MR_RST;
    end else if (bus_wr) begin
      if (wb_adr_i == ADR_MR0) begin
        mr0_q <= merge16(mr0_q, wb_dat_i, wb_sel_i);
      end else if (wb_adr_i == ADR_MR1) begin
        mr1_q <= merge16(mr1_q, wb_dat_i, wb_sel_i);
      end else if (wb_adr_i == ADR_MR2) begin
        mr2_q <= merge16(mr2_q, wb_dat_i, wb_sel_i);
      end
    end
  end

  // Latency register, one byte lane per field
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cl_q  <= CL_INIT;
      cwl_q <= CWL_INIT;
    end else if (bus_wr && (wb_adr_i == ADR_LAT)) begin
      if (wb_sel_i[0]) begin
        cl_q <= wb_dat_i[LAT_CL_LSB +: CK_FIELD_W];
      end
      if (wb_sel_i[1]) begin
        cwl_q <= wb_dat_i[LAT_CWL_LSB +: CK_FIELD_W];
      end
    end
  end

  // Live status word
  always_comb begin
    status                           = 32'h0000_0000;
    status[ST_TERM_ON]               = term_on_q;
    status[ST_STR_LSB +: 3]          = strength_q;
    status[ST_WR_WIN]                = win_q;
    status[ST_SYNC]                  = sync_q;
    status[ST_DYN_EN]                = dyn_en;
    status[ST_CFG_BAD]               = cfg_bad;
    status[ST_DLL_WR]                = dyn_en & !dll_locked_i;
    status[ST_HOLD_ERR]              = hold_err_q;
  end

  // Read data and acknowledge; unmapped addresses read zero
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ack_q  <= 1'b0;
      rdat_q <= 32'h0000_0000;
    end else begin
      ack_q <= bus_req;
      if (bus_req && !wb_we_i) begin
        if (wb_adr_i == ADR_MR0) begin
          rdat_q <= {16'h0000, mr0_q};
        end else if (wb_adr_i == ADR_MR1) begin
          rdat_q <= {16'h0000, mr1_q};
        end else if (wb_adr_i == ADR_MR2) begin
          rdat_q <= {16'h0000, mr2_q};
        end else if (wb_adr_i == ADR_LAT) begin
          rdat_q <= {19'h0, cwl_q, 3'h0, cl_q};
        end else if (wb_adr_i == ADR_STAT) begin
          rdat_q <= status;
        end else begin
          rdat_q <= 32'h0000_0000;
        end
      end
    end
  end

  // Hold time check on the control ball
  assign hold_viol = ball_prev_q & !ball & (hold_cnt_q < hold_need_q);

  // Count clocks since the ball rose or a write was taken with it high
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ball_prev_q <= 1'b0;
      hold_cnt_q  <= 3'h0;
      hold_need_q <= 3'h0;
    end else begin
      ball_prev_q <= ball;
      if (ball && wr_cmd_i) begin
        hold_cnt_q  <= 3'h1;
        hold_need_q <= chop ? 3'(HOLD_CHOP) : 3'(HOLD_FULL);
      end else if (ball && !ball_prev_q) begin
        hold_cnt_q  <= 3'h1;
        hold_need_q <= 3'(HOLD_CHOP);
      end else if (ball && (hold_cnt_q != HOLD_CNT_MAX)) begin
        hold_cnt_q  <= 3'(hold_cnt_q + 3'h1);
      end
    end
  end

  // Sticky hold error; a new error beats a clear in the same cycle
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      hold_err_q <= 1'b0;
    end else if (hold_viol) begin
      hold_err_q <= 1'b1;
    end else if (bus_wr && (wb_adr_i == ADR_STAT) && wb_sel_i[1] && wb_dat_i[ST_HOLD_ERR]) begin
      hold_err_q <= 1'b0;
    end
  end

  // Write window: a new switch point beats a return in the same cycle
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      win_q <= 1'b0;
    end else if (sched.switch_evt && dyn_en) begin
      win_q <= 1'b1;
    end else if (sched.return_evt || !dyn_en) begin
      win_q <= 1'b0;
    end
  end

  // Strength chosen for the next cycle
  always_comb begin
    if (sched.switch_evt && dyn_en) begin
      strength_d = wr_str;
    end else if (win_q && !sched.return_evt && dyn_en) begin
      strength_d = wr_str;
    end else begin
      strength_d = nom_str;
    end
  end

  // Termination timing from the delayed ball, independent of writes
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      term_on_q  <= 1'b0;
      strength_q <= STR_OFF;
      sync_q     <= 1'b0;
    end else begin
      sync_q     <= sync_ok;
      term_on_q  <= sync_ok & sched.ball_late;
      strength_q <= strength_d;
    end
  end

  // Skew window around each strength change point
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      skew_cnt_q <= 2'h0;
      undef_q    <= 1'b0;
    end else if (dyn_en && (sched.switch_evt || sched.return_evt)) begin
      skew_cnt_q <= SKEW_CYCLES;
      undef_q    <= 1'b1;
    end else begin
      skew_cnt_q <= (skew_cnt_q != 2'h0) ? 2'(skew_cnt_q - 2'h1) : 2'h0;
      undef_q    <= (skew_cnt_q > 2'h1);
    end
  end

  // Outputs straight from flip-flops
  assign wb_ack_o             = ack_q;
  assign wb_dat_o             = rdat_q;
  assign term_on_o            = term_on_q;
  assign term_strength_o      = strength_q;
  assign strength_undefined_o = undef_q;
  assign write_window_o       = win_q;
  assign sync_mode_o          = sync_q;
endmodule : dtc_termination_ctl

// *** testbench/dtc_chk_sva.sv ***
`timescale 1ns/1ps
module dtc_chk
  import dtc_pkg::*;
(
  // Clock and reset
  input wire logic          clock_i,
  input wire logic          rst_b_i,
  // Register bus
  input wire logic          wb_cyc_i,
  input wire logic          wb_stb_i,
  input wire logic          wb_we_i,
  input wire logic [7:0]    wb_adr_i,
  input wire logic [31:0]   wb_dat_i,
  input wire logic          wb_ack_o,
  // Ball, commands and state
  input wire logic          term_ctl_i,
  input wire logic          wr_cmd_i,
  input wire logic          otf_chop_i,
  input wire logic          self_refresh_i,
  input wire logic          dll_locked_i,
  // Termination outputs
  input wire logic          term_on_o,
  input wire dtc_pkg::dtc_strength_t term_strength_o,
  input wire logic          strength_undefined_o,
  input wire logic          write_window_o,
  input wire logic          sync_mode_o
);
  logic [63:0]   ball_h, wr_h, ch_h;
  logic [15:0]   mr0_q, mr1_q, mr2_q, lat_q;
  logic [5:0]    calm_q;
  logic          take, calm, dyn;
  int            al, lat;
  dtc_strength_t nom_s;
  // Shadow latency and strengths; calm means settings and mode are old enough to judge
  assign take = wb_cyc_i & wb_stb_i & wb_we_i & ~wb_ack_o;
  assign calm = calm_q == 6'h3f;
  assign dyn = mr2_q[10:9] != 2'h0;
  assign al = (mr1_q[4:3] == AL_CL_M1) ? int'(lat_q[4:0]) - 1 : (mr1_q[4:3] == AL_CL_M2) ? int'(lat_q[4:0]) - 2 : 0;
  assign lat = int'(lat_q[12:8]) + al - 2;
  assign nom_s = ({mr1_q[9], mr1_q[6], mr1_q[2]} > 3'h5) ? STR_RESERVED :
                 dtc_strength_t'({mr1_q[9], mr1_q[6], mr1_q[2]});
  // History of ball, writes and chop, newest in bit 0
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ball_h <= '0;
      wr_h <= '0;
      ch_h <= '0;
      calm_q <= '0;
    end else begin
      ball_h <= {ball_h[62:0], term_ctl_i & ~self_refresh_i};
      wr_h <= {wr_h[62:0], wr_cmd_i};
      ch_h <= {ch_h[62:0], mr0_q[1:0] == BL_FIXED4 || (mr0_q[1:0] == BL_OTF && otf_chop_i)};
      calm_q <= (take || $changed(sync_mode_o)) ? 6'h00 : calm_q + {5'h00, !calm};
    end
  end
  // Copy of the mode and latency registers
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      mr0_q <= 16'h0000;
      mr1_q <= 16'h0000;
      mr2_q <= 16'h0000;
      lat_q <= {3'h0, CWL_RST, 3'h0, CL_RST};
    end else if (take) begin
      if (wb_adr_i == ADR_MR0) mr0_q <= wb_dat_i[15:0];
      if (wb_adr_i == ADR_MR1) mr1_q <= wb_dat_i[15:0];
      if (wb_adr_i == ADR_MR2) mr2_q <= wb_dat_i[15:0];
      if (wb_adr_i == ADR_LAT) lat_q <= wb_dat_i[15:0];
    end
  end
  default clocking @(posedge clock_i); endclocking
  default disable iff (!rst_b_i);
  bus_ack_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
    else $error("bus ack not a single pulse");
  on_latency_a: assert property (
    calm |-> term_on_o == (sync_mode_o && ball_h[lat])) else $error("termination on at wrong time");
  sync_gate_a: assert property (
    self_refresh_i || !dll_locked_i |=> !sync_mode_o) else $error("sync mode while not allowed");
  sw_undef_a: assert property ($rose(write_window_o) |-> strength_undefined_o)
    else $error("no skew mark at switch");
  ret_undef_a: assert property ($fell(write_window_o) |-> strength_undefined_o)
    else $error("no skew mark at return");
  sw_time_a: assert property (
    calm && dyn && wr_h[lat] |-> write_window_o && term_strength_o == dtc_strength_t'({1'b0, mr2_q[10:9]}))
    else $error("write strength not applied in time");
  hold_full_a: assert property (calm && dyn && wr_h[lat+5] && !ch_h[lat+5] |-> write_window_o)
    else $error("full burst window ended early");
  ret_full_a: assert property (
    calm && wr_h[lat+6] && !ch_h[lat+6] && wr_h[lat+:6] == 6'h00 |-> !write_window_o)
    else $error("full burst window ended late");
  ret_chop_a: assert property (
    calm && wr_h[lat+4] && ch_h[lat+4] && wr_h[lat+:4] == 4'h0 |-> !write_window_o)
    else $error("chop window ended late");
  no_dyn_a: assert property (calm && !dyn |-> !write_window_o)
    else $error("window with write strength off");
  nom_out_a: assert property (
    calm && !write_window_o && !strength_undefined_o |-> term_strength_o == nom_s)
    else $error("nominal strength wrong");
endmodule : dtc_chk
bind dtc_termination_ctl dtc_chk chk_u (.clock_i(clock_i), .rst_b_i(rst_b_i), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_ack_o(wb_ack_o),
  .term_ctl_i(term_ctl_i), .wr_cmd_i(wr_cmd_i), .otf_chop_i(otf_chop_i), .self_refresh_i(self_refresh_i),
  .dll_locked_i(dll_locked_i), .term_on_o(term_on_o), .term_strength_o(term_strength_o),
  .strength_undefined_o(strength_undefined_o), .write_window_o(write_window_o), .sync_mode_o(sync_mode_o));

// *** testbench/dtc_ctl_model.sv ***
`timescale 1ns/1ps
module dtc_ctl_model (
  // Clock and reset
  input wire logic       clock_i,
  input wire logic       rst_b_i,
  // Requests from the bench
  input wire logic       go_i,
  input wire logic       with_wr_i,
  input wire logic       full_i,
  input wire logic [3:0] extra_i,
  // Ball and write command
  output logic           ball_o,
  output logic           wr_o,
  output logic           chop_o
);
  logic [4:0] left_q;
  // Raise the ball with an optional write and keep it up for the minimum high time plus slack
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      left_q <= 5'h00;
      wr_o <= 1'b0;
      chop_o <= 1'b0;
    end else begin
      wr_o <= go_i & with_wr_i;
      chop_o <= go_i & with_wr_i & ~full_i;
      if (go_i) left_q <= ((with_wr_i && full_i) ? 5'h06 : 5'h04) + {1'b0, extra_i};
      else if (left_q != 5'h00) left_q <= left_q - 5'h01;
    end
  end
  // Ball rests low outside requests so no read ever sees termination
  assign ball_o = left_q != 5'h00;
endmodule : dtc_ctl_model

// *** testbench/tb.sv ***
`timescale 1ns/1ps
module tb;
  import dtc_pkg::*;
  logic          clock_i, ack, ball, wrc, chop, on, undef, win, sync;
  logic          rst_b_i = 1'b0, cyc = 1'b0, we = 1'b0, go = 1'b0, with_wr = 1'b0, full = 1'b0;
  logic          dll = 1'b1, sr = 1'b0, cke = 1'b1, pd = 1'b0, bank = 1'b0;
  logic [3:0]    extra = 4'h0;
  logic [7:0]    adr = 8'h00;
  logic [31:0]   dat = 32'h0, rdat, got;
  dtc_strength_t str;
  logic [2:0]    mr_w;
  int            n_mismatch = 0, total_checks = 0, rise, len;
  dtc_termination_ctl dut_u (.clock_i(clock_i), .rst_b_i(rst_b_i), .wb_cyc_i(cyc), .wb_stb_i(cyc),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'h3), .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .term_ctl_i(ball), .wr_cmd_i(wrc), .otf_chop_i(chop), .cke_i(cke), .self_refresh_i(sr),
    .power_down_i(pd), .bank_open_i(bank), .dll_locked_i(dll), .term_on_o(on), .term_strength_o(str),
    .strength_undefined_o(undef), .write_window_o(win), .sync_mode_o(sync));
  dtc_ctl_model ctl_u (.clock_i(clock_i), .rst_b_i(rst_b_i), .go_i(go), .with_wr_i(with_wr),
    .full_i(full), .extra_i(extra), .ball_o(ball), .wr_o(wrc), .chop_o(chop));
  initial begin
    clock_i = 1'b0;
    forever #2.5 clock_i = ~clock_i;
  end
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] seen);
    total_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  // One classic cycle; values read before the edge's updates land
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge clock_i);
    cyc <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    do begin
      @(posedge clock_i);
      k++;
    end while (ack !== 1'b1 && k < 50);
    got = rdat;
    cyc <= 1'b0;
    if (k == 50) n_mismatch++;
  endtask : bus
  // Ball pulse, optionally with a write, once the checker's settle count has run out;
  // measures delay to output rise and its length
  task automatic pulse(input logic w, input logic f, input logic s);
    repeat (64) @(posedge clock_i);
    @(posedge clock_i);
    go <= 1'b1;
    with_wr <= w;
    full <= f;
    @(posedge clock_i);
    go <= 1'b0;
    rise = 0;
    len = 0;
    while ((s ? win : on) !== 1'b1 && rise < 40) begin
      @(posedge clock_i);
      rise++;
    end
    if (s && rise < 40) chk("write strength", {29'h0, mr_w}, {29'h0, 3'(str)});
    while ((s ? win : on) === 1'b1 && len < 40) begin
      @(posedge clock_i);
      len++;
    end
  endtask : pulse
  task automatic t_regs;
    bus(1'b0, ADR_LAT, 32'h0);
    chk("lat reset", {16'h0, 3'h0, CWL_RST, 3'h0, CL_RST}, got);
    bus(1'b1, 8'h20, 32'hffff);
    bus(1'b0, 8'h20, 32'h0);
    chk("unmapped", 32'h0, got);
  endtask : t_regs
  task automatic t_nom;
    for (int c = 0; c < 8; c++) begin
      bus(1'b1, ADR_MR1, {22'h0, c[2], 2'h0, c[1], 3'h0, c[0], 2'h0});
      bus(1'b0, ADR_STAT, 32'h0);
      chk("nominal", (c > 5) ? 32'h6 : 32'(c), {29'h0, got[3:1]});
      chk("bad cfg", {31'h0, c > 5}, {31'h0, got[ST_CFG_BAD]});
    end
  endtask : t_nom
  // Entries: dll, self refresh, cke, power down, bank open, MR0 bit 12, expected sync
  logic [6:0] tbl [6] = '{7'h51, 7'h10, 7'h70, 7'h4d, 7'h48, 7'h4b};
  task automatic t_sync;
    bus(1'b1, ADR_MR1, 32'h40);
    foreach (tbl[i]) begin
      bus(1'b1, ADR_MR0, {19'h0, tbl[i][1], 12'h001});
      {dll, sr, cke, pd, bank} <= tbl[i][6:2];
      repeat (3) @(posedge clock_i);
      chk("sync", {31'h0, tbl[i][0]}, {31'h0, sync});
    end
    {dll, sr, cke, pd, bank} <= 5'h14;
    bus(1'b1, ADR_MR1, 32'h0);
    repeat (3) @(posedge clock_i);
    chk("sync off", 32'h0, {31'h0, sync});
  endtask : t_sync
  task automatic t_lat;
    for (int ac = 0; ac < 3; ac++) begin
      bus(1'b1, ADR_MR1, 32'h4 | (ac << 3));
      extra <= 4'(ac);
      pulse(1'b0, 1'b0, 1'b0);
      chk("on delay", 32'(int'(CWL_RST) + (ac == 1 ? int'(CL_RST) - 1 : (ac == 2 ? int'(CL_RST) - 2 : 0)) - 2 + 2), rise);
      chk("on length", 32'(4 + ac), len);
    end
    extra <= 4'h0;
  endtask : t_lat
  // Entries: write code, burst mode, full request, long window
  logic [5:0] dyn [5] = '{6'h17, 6'h24, 6'h1a, 6'h23, 6'h07};
  task automatic t_dyn;
    bus(1'b1, ADR_MR1, 32'h4);
    foreach (dyn[i]) begin
      mr_w = {1'b0, dyn[i][5:4]};
      bus(1'b1, ADR_MR2, {21'h0, dyn[i][5:4], 9'h0});
      bus(1'b1, ADR_MR0, {30'h0, dyn[i][3:2]});
      pulse(1'b1, dyn[i][1], 1'b1);
      if (mr_w != 3'h0) chk("switch delay", 32'h5, rise);
      else chk("nominal kept", 32'(STR_DIV4), {29'h0, 3'(str)});
      chk("window", (mr_w == 3'h0) ? 32'h0 : (dyn[i][0] ? 32'h6 : 32'h4), len);
    end
    bus(1'b0, ADR_STAT, 32'h0);
    chk("hold error", 32'h0, {31'h0, got[ST_HOLD_ERR]});
  endtask : t_dyn
  task automatic stop_test;
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : stop_test
  initial begin
    repeat (10) @(posedge clock_i);
    rst_b_i <= 1'b1;
    t_regs;
    t_nom;
    t_sync;
    t_lat;
    t_dyn;
    stop_test;
  end
  // Watchdog at 40000 cycles, well beyond the fewer than one thousand cycles the run needs
  initial begin
    #200000;
    n_mismatch++;
    stop_test;
  end
endmodule : tb
